//--- core/pmseq_pkg.sv
// constants, offsets, field positions and states of the operating mode sequencer
package pmseq_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int RESET_K_NS_PER_NF = 1000000;
   localparam int RESET_CAP_NF = 1;
   localparam int DEGLITCH_NS = 5000000;
   localparam int RESET_CYCLES_DEF = RESET_K_NS_PER_NF * RESET_CAP_NF / CLK_PERIOD_NS;
   localparam int DEGLITCH_CYCLES_DEF = DEGLITCH_NS / CLK_PERIOD_NS;
   localparam logic [31:0] SEQ_CYCLES = 32'h00000010;
   localparam logic [31:0] PG_SETTLE_CYCLES = 32'h00000008;

   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PGSTAT = 8'h04;
   localparam logic [7:0] A_MASK = 8'h08;
   localparam logic [7:0] A_MODE = 8'h0C;
   localparam logic [7:0] A_REGEN = 8'h10;
   localparam logic [7:0] A_PERIPH = 8'h14;
   localparam logic [7:0] A_BUCK = 8'h18;

   localparam int CTRL_STBY = 7;
   localparam int CTRL_SLEEP = 6;
   localparam int CTRL_LOADED = 1;
   localparam int CTRL_SWRST = 0;

   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [7:0] REGEN_RST = 8'h01;
   localparam logic [31:0] PERIPH_RST = 32'h00000000;
   localparam logic [31:0] BUCK_RST = 32'h00000000;
   localparam int BUCK_ONE_LSB = 0;
   localparam int BUCK_TWO_LSB = 8;
   localparam int BUCK_ONE_STBY_LSB = 16;
   localparam int BUCK_TWO_STBY_LSB = 24;
   localparam int VSEL_W = 6;

   localparam int PIN_W = 14;
   localparam int PIN_HWRST = 0;
   localparam int PIN_THERM = 1;
   localparam int PIN_SYSLOW = 2;
   localparam int PIN_UVLO = 3;
   localparam int PIN_INPWR = 4;
   localparam int PIN_STBY = 5;
   localparam int PIN_PG_LSB = 6;
   localparam logic [PIN_W-1:0] PIN_RST = 14'h0001;

   typedef enum logic [2:0] {
      ST_NOPWR = 3'b000,
      ST_ENABLE = 3'b001,
      ST_SEQ = 3'b011,
      ST_RESET = 3'b010,
      ST_PGCHK = 3'b110,
      ST_NORMAL = 3'b111,
      ST_SLEEP = 3'b101
   } pmseq_state_e;
endpackage

//--- core/pmseq_if.sv
// conditioned pin levels and hardware reset events
`timescale 1ns/1ps
interface pmseq_if;
   logic [pmseq_pkg::PIN_W-1:0] pins;
   logic hw_qual;
   logic hw_rise;
   modport cond (output pins, output hw_qual, output hw_rise);
   modport seq (input pins, input hw_qual, input hw_rise);
endinterface

//--- core/pmseq_cond.sv
// pin synchronisers and hardware reset deglitch
`timescale 1ns/1ps
module pmseq_cond import pmseq_pkg::*; #(
   parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYCLES_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [PIN_W-1:0] pins_raw,
   pmseq_if.cond sif
);
   logic [PIN_W-1:0] s1_r;
   logic [PIN_W-1:0] s2_r;
   logic [PIN_W-1:0] s3_r;
   logic [PIN_W-1:0] q_r;
   logic [31:0] cnt_r;
   logic qual_r;
   logic rise_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= PIN_RST;
         s2_r <= PIN_RST;
         s3_r <= PIN_RST;
      end else begin
         s1_r <= pins_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   for (genvar i = 0; i < PIN_W; i++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            q_r[i] <= PIN_RST[i];
         end else if (s2_r[i] == s3_r[i]) begin
            q_r[i] <= s3_r[i];
         end
      end
   end

   // low must persist the deglitch time before it qualifies
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 32'h00000000;
         qual_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         rise_r <= q_r[PIN_HWRST] && qual_r;
         if (!q_r[PIN_HWRST]) begin
            if (cnt_r != 32'(DEGLITCH_CYCLES - 1)) begin
               cnt_r <= cnt_r + 32'h00000001;
            end else begin
               qual_r <= 1'b1;
            end
         end else begin
            cnt_r <= 32'h00000000;
            qual_r <= 1'b0;
         end
      end
   end

   assign sif.pins = q_r;
   assign sif.hw_qual = qual_r;
   assign sif.hw_rise = rise_r;
endmodule

//--- core/pmseq_top.sv
// operating mode sequencer with apb register file
// Functional notes
// - reset state drives system reset low for timer
// - ignore power-good in reset; timer ends to check
// - interrupt driver off while reset low
// - check state enables comparators, flags low supplies
// - check ends in sleep on fault, else normal
// - masked supply still reports status, no transition
// - fault mask resets to all masked
// - normal: thermal/lowvolt to sleep, pgfault to nopower
// - normal: software or hardware reset to reset
// - normal: sleep request bit enters sleep
// - software reset keeps register contents
// - sleep drives reset low, defaults some registers
// - sleep disables regulators and sequencing
// - leaving sleep sequences with defaulted values
// - thermal sleep ends only at undervoltage
// - other sleep ends on input power connect
// - input removal then reconnect leaves sleep
// - standby sets buck standby voltages and pfm
// - deglitched hardware low resets, rise starts reset
// - hardware reset low forces register defaults
// - hardware reset or no-power defaults clear loaded flag; sleep keeps it
// - unmasked status toggle is a power-good fault
`timescale 1ns/1ps
module pmseq_top import pmseq_pkg::*; #(
   parameter int unsigned RESET_CYCLES = RESET_CYCLES_DEF,
   parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYCLES_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hardware_reset_in,
   input wire logic thermal_fault_in,
   input wire logic system_voltage_low_in,
   input wire logic uvlo_in,
   input wire logic input_power_in,
   input wire logic standby_pin_in,
   input wire logic [7:0] supply_below_target,
   input wire logic irq_request,
   output logic system_reset_out,
   output logic int_out,
   output logic int_oe_n,
   output logic pg_comparator_en,
   output logic [7:0] regulator_enable,
   output logic sequencing_active,
   output logic [VSEL_W-1:0] buck_one_vsel,
   output logic [VSEL_W-1:0] buck_two_vsel,
   output logic buck_pfm,
   output logic [31:0] periph_ctrl
);
   pmseq_if sif ();

   pmseq_cond #(
      .DEGLITCH_CYCLES(DEGLITCH_CYCLES)
   ) u_cond (
      .pclk(pclk),
      .presetn(presetn),
      .pins_raw({supply_below_target, standby_pin_in, input_power_in, uvlo_in,
                 system_voltage_low_in, thermal_fault_in, hardware_reset_in}),
      .sif(sif)
   );

   // register index 7 marks an unmapped address
   function automatic logic [2:0] reg_idx(input logic [7:0] a);
      if (a == A_CTRL) begin
         reg_idx = 3'h0;
      end else if (a == A_PGSTAT) begin
         reg_idx = 3'h1;
      end else if (a == A_MASK) begin
         reg_idx = 3'h2;
      end else if (a == A_MODE) begin
         reg_idx = 3'h3;
      end else if (a == A_REGEN) begin
         reg_idx = 3'h4;
      end else if (a == A_PERIPH) begin
         reg_idx = 3'h5;
      end else if (a == A_BUCK) begin
         reg_idx = 3'h6;
      end else begin
         reg_idx = 3'h7;
      end
   endfunction

   pmseq_state_e state_r, state_nxt;
   logic [31:0] cnt_r, periph_r, buck_r, prdata_r;
   logic stby_r, sleep_req_r, loaded_r, swrst_r, sleep_thermal_r, in_gone_r;
   logic [7:0] mask_r, pg_stat_r, pg_prev_r, regen_r, reg_en_out_r;
   logic pready_r, pslverr_r, sys_rst_r, int_oe_n_r, pg_en_r, seq_act_r, pfm_r;
   logic [VSEL_W-1:0] v1_r, v2_r;

   logic hw_low, therm, syslow, uvlo, inpwr, pg_evt, pg_fault;
   logic acc_swrst, acc_sleep, enter_sleep, enter_nopwr, wr, rd, stby_on;
   logic [2:0] idx;

   assign hw_low = !sif.pins[PIN_HWRST];
   assign therm = sif.pins[PIN_THERM];
   assign syslow = sif.pins[PIN_SYSLOW];
   assign uvlo = sif.pins[PIN_UVLO];
   assign inpwr = sif.pins[PIN_INPWR];
   assign idx = reg_idx(paddr);
   assign wr = psel && penable && pwrite && pready_r;
   assign rd = psel && penable && !pwrite && !pready_r;
   assign pg_evt = |((pg_stat_r ^ pg_prev_r) & ~mask_r);
   assign pg_fault = |(pg_stat_r & ~mask_r);
   assign enter_sleep = (state_nxt == ST_SLEEP) && (state_r != ST_SLEEP);
   assign enter_nopwr = (state_nxt == ST_NOPWR) && (state_r != ST_NOPWR);
   assign stby_on = (state_r == ST_NORMAL) && (stby_r || sif.pins[PIN_STBY]);

   always_comb begin
      state_nxt = state_r;
      acc_swrst = 1'b0;
      acc_sleep = 1'b0;
      case (state_r)
         ST_NOPWR: begin
            if (!uvlo) begin
               state_nxt = ST_ENABLE;
            end
         end
         ST_ENABLE: begin
            if (!syslow) begin
               state_nxt = ST_SEQ;
            end
         end
         ST_SEQ: begin
            if (cnt_r == SEQ_CYCLES - 32'h00000001) begin
               state_nxt = ST_RESET;
            end
         end
         ST_RESET: begin
            if (cnt_r == 32'(RESET_CYCLES - 1)) begin
               state_nxt = ST_PGCHK;
            end
         end
         ST_PGCHK: begin
            if (cnt_r == PG_SETTLE_CYCLES - 32'h00000001) begin
               state_nxt = pg_fault ? ST_SLEEP : ST_NORMAL;
            end
         end
         ST_NORMAL: begin
            if (therm || syslow) begin
               state_nxt = ST_SLEEP;
            end else if (pg_evt) begin
               state_nxt = ST_NOPWR;
            end else if (swrst_r) begin
               state_nxt = ST_RESET;
               acc_swrst = 1'b1;
            end else if (sleep_req_r) begin
               state_nxt = ST_SLEEP;
               acc_sleep = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (!sleep_thermal_r && in_gone_r && inpwr) begin
               state_nxt = ST_ENABLE;
            end
         end
         default: begin
            state_nxt = ST_NOPWR;
         end
      endcase
      if (sif.hw_rise && (state_r != ST_NOPWR) && (state_r != ST_SLEEP)) begin
         state_nxt = ST_RESET;
      end
      if (uvlo) begin
         state_nxt = ST_NOPWR;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_NOPWR;
         cnt_r <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r) begin
            cnt_r <= 32'h00000000;
         end else begin
            cnt_r <= cnt_r + 32'h00000001;
         end
      end
   end

   // sleep cause and input power cycling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_thermal_r <= 1'b0;
         in_gone_r <= 1'b0;
      end else if (enter_sleep) begin
         sleep_thermal_r <= (state_r == ST_NORMAL) && therm;
         in_gone_r <= !inpwr;
      end else if ((state_r == ST_SLEEP) && !inpwr) begin
         in_gone_r <= 1'b1;
      end
   end

   // supply status, sampled only while comparators run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_stat_r <= 8'h00;
         pg_prev_r <= 8'h00;
      end else begin
         if ((state_r == ST_PGCHK) || (state_r == ST_NORMAL)) begin
            pg_stat_r <= sif.pins[PIN_PG_LSB +: 8];
         end
         pg_prev_r <= pg_stat_r;
      end
   end

   // control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stby_r <= 1'b0;
         sleep_req_r <= 1'b0;
         loaded_r <= 1'b0;
         swrst_r <= 1'b0;
      end else if (hw_low || enter_nopwr) begin
         stby_r <= 1'b0;
         sleep_req_r <= 1'b0;
         loaded_r <= 1'b0;
         swrst_r <= 1'b0;
      end else begin
         if (acc_swrst) begin
            swrst_r <= 1'b0;
         end
         if (acc_sleep) begin
            sleep_req_r <= 1'b0;
         end
         if (wr && (idx == 3'h0)) begin
            stby_r <= pwdata[CTRL_STBY];
            sleep_req_r <= pwdata[CTRL_SLEEP];
            loaded_r <= pwdata[CTRL_LOADED];
            swrst_r <= pwdata[CTRL_SWRST];
         end
      end
   end

   // mask and buck settings keep values through sleep and software reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= MASK_RST;
         buck_r <= BUCK_RST;
      end else if (hw_low || enter_nopwr) begin
         mask_r <= MASK_RST;
         buck_r <= BUCK_RST;
      end else if (wr && (idx == 3'h2)) begin
         mask_r <= pwdata[7:0];
      end else if (wr && (idx == 3'h6)) begin
         buck_r <= pwdata;
      end
   end

   // regulator and peripheral controls return to defaults on sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regen_r <= REGEN_RST;
         periph_r <= PERIPH_RST;
      end else if (hw_low || enter_nopwr || enter_sleep) begin
         regen_r <= REGEN_RST;
         periph_r <= PERIPH_RST;
      end else if (wr && (idx == 3'h4)) begin
         regen_r <= pwdata[7:0];
      end else if (wr && (idx == 3'h5)) begin
         periph_r <= pwdata;
      end
   end

   // apb slave: one wait state, answer registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && (idx == 3'h7);
         if (rd) begin
            case (idx)
               3'h0: prdata_r <= {24'h000000, stby_r, sleep_req_r, 4'h0, loaded_r, swrst_r};
               3'h1: prdata_r <= {24'h000000, pg_stat_r};
               3'h2: prdata_r <= {24'h000000, mask_r};
               3'h3: prdata_r <= {26'h0000000, sif.hw_qual, sleep_thermal_r, 1'b0, state_r};
               3'h4: prdata_r <= {24'h000000, regen_r};
               3'h5: prdata_r <= periph_r;
               3'h6: prdata_r <= buck_r;
               default: prdata_r <= 32'h00000000;
            endcase
         end else begin
            prdata_r <= 32'h00000000;
         end
      end
   end

   // pin and supply outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_rst_r <= 1'b0;
         int_oe_n_r <= 1'b1;
         pg_en_r <= 1'b0;
         reg_en_out_r <= 8'h00;
         seq_act_r <= 1'b0;
      end else begin
         sys_rst_r <= ((state_nxt == ST_PGCHK) || (state_nxt == ST_NORMAL))
                      && !sif.hw_qual;
         int_oe_n_r <= !(sys_rst_r && irq_request);
         pg_en_r <= (state_nxt == ST_PGCHK) || (state_nxt == ST_NORMAL);
         seq_act_r <= (state_nxt == ST_SEQ) || (state_nxt == ST_RESET)
                      || (state_nxt == ST_PGCHK) || (state_nxt == ST_NORMAL);
         if ((state_nxt == ST_SLEEP) || (state_nxt == ST_NOPWR) || (state_nxt == ST_ENABLE)) begin
            reg_en_out_r <= 8'h00;
         end else begin
            reg_en_out_r <= regen_r;
         end
      end
   end

   // buck voltage selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         v1_r <= BUCK_RST[BUCK_ONE_LSB +: VSEL_W];
         v2_r <= BUCK_RST[BUCK_TWO_LSB +: VSEL_W];
         pfm_r <= 1'b0;
      end else if (stby_on) begin
         v1_r <= buck_r[BUCK_ONE_STBY_LSB +: VSEL_W];
         v2_r <= buck_r[BUCK_TWO_STBY_LSB +: VSEL_W];
         pfm_r <= 1'b1;
      end else begin
         v1_r <= buck_r[BUCK_ONE_LSB +: VSEL_W];
         v2_r <= buck_r[BUCK_TWO_LSB +: VSEL_W];
         pfm_r <= 1'b0;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign system_reset_out = sys_rst_r;
   assign int_out = 1'b0;
   assign int_oe_n = int_oe_n_r;
   assign pg_comparator_en = pg_en_r;
   assign regulator_enable = reg_en_out_r;
   assign sequencing_active = seq_act_r;
   assign buck_one_vsel = v1_r;
   assign buck_two_vsel = v2_r;
   assign buck_pfm = pfm_r;
   assign periph_ctrl = periph_r;
endmodule

//--- tb/pmseq_checker.sv
// port-level assertions for the operating mode sequencer
`timescale 1ns/1ps
module pmseq_checker import pmseq_pkg::*; #(
   parameter int unsigned RESET_CYCLES = RESET_CYCLES_DEF,
   parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYCLES_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq_request,
   input wire logic system_reset_out,
   input wire logic int_oe_n,
   input wire logic pg_comparator_en,
   input wire logic [7:0] regulator_enable,
   input wire logic sequencing_active
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [31:0] low_cnt_r;
   // consecutive cycles with the system held in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_r <= 32'h00000000;
      end else if (system_reset_out) begin
         low_cnt_r <= 32'h00000000;
      end else begin
         low_cnt_r <= low_cnt_r + 32'h00000001;
      end
   end
   AST_RESET_HOLD: assert property ($rose(system_reset_out) |-> low_cnt_r >= RESET_CYCLES)
      else $error("reset output released too early");
   AST_INT_OFF: assert property ((!system_reset_out && !$past(system_reset_out)) |-> int_oe_n)
      else $error("interrupt driven while system in reset");
   AST_INT_ON: assert property ((system_reset_out && irq_request) |=> !int_oe_n)
      else $error("pending interrupt not driven");
   AST_PG_ON_RISE: assert property ($rose(system_reset_out) |-> pg_comparator_en)
      else $error("comparators off at check entry");
   AST_SLEEP_NO_REG: assert property (!sequencing_active |-> regulator_enable == 8'h00)
      else $error("regulator enabled while sequencing off");
   AST_SLEEP_RST_LOW: assert property (!sequencing_active |-> !system_reset_out)
      else $error("reset output high while sequencing off");
   AST_READY_PULSE: assert property ((psel && penable && !pready) |=> pready ##1 !pready)
      else $error("ready not a single pulse after access");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000)
      else $error("read data outside ready cycle");
endmodule

bind pmseq_top pmseq_checker #(.RESET_CYCLES(RESET_CYCLES), .DEGLITCH_CYCLES(DEGLITCH_CYCLES)) i_pmseq_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq_request(irq_request), .system_reset_out(system_reset_out), .int_oe_n(int_oe_n),
   .pg_comparator_en(pg_comparator_en), .regulator_enable(regulator_enable), .sequencing_active(sequencing_active));

//--- tb/pmseq_host.sv
// host model: apb master that keeps off the bus while the system is in reset
`timescale 1ns/1ps
module pmseq_host (
   input wire logic pclk,
   input wire logic system_reset_out,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic [7:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata
);
   initial begin
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h00000000;
   end
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output logic ok);
      int n;
      n = 0;
      q = 32'h00000000;
      e = 1'b0;
      do begin
         @(posedge pclk);
         n++;
      end while (system_reset_out !== 1'b1 && n < 400);
      ok = (system_reset_out === 1'b1);
      if (ok) begin
         paddr <= a;
         pwrite <= w;
         pwdata <= d;
         psel <= 1'b1;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (pready !== 1'b1 && n < 50);
         ok = (pready === 1'b1);
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         paddr <= ~a;
         pwdata <= ~d;
      end
   endtask
endmodule

//--- tb/pmseq_top_test.sv
// self-checking bench for the operating mode sequencer
`timescale 1ns/1ps
module pmseq_top_test import pmseq_pkg::*;;
   localparam int unsigned RC = 20;
   localparam int unsigned DG = 10;
   logic pclk, presetn, hw_rst_n, therm, syslow, uvlo, inpwr, stby, irq, psel, penable, pwrite, pready, pslverr;
   logic sro, int_out, int_oe_n, pg_en, seq_act, pfm;
   logic [7:0] paddr, supply, regen;
   logic [31:0] pwdata, prdata, periph;
   logic [VSEL_W-1:0] v1, v2;
   int fail_count = 0;
   int num_checks = 0;

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   pmseq_top #(.RESET_CYCLES(RC), .DEGLITCH_CYCLES(DG)) i_pmseq_top (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hardware_reset_in(hw_rst_n),
      .thermal_fault_in(therm), .system_voltage_low_in(syslow), .uvlo_in(uvlo), .input_power_in(inpwr),
      .standby_pin_in(stby), .supply_below_target(supply), .irq_request(irq), .system_reset_out(sro),
      .int_out(int_out), .int_oe_n(int_oe_n), .pg_comparator_en(pg_en), .regulator_enable(regen),
      .sequencing_active(seq_act), .buck_one_vsel(v1), .buck_two_vsel(v2), .buck_pfm(pfm), .periph_ctrl(periph));

   pmseq_host i_pmseq_host (.pclk(pclk), .system_reset_out(sro), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic need(input logic ok, input string what);
      if (ok !== 1'b1) begin
         fail_count++;
         $display("Error %0t: %s timed out", $time, what);
         test_done();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e, ok;
      i_pmseq_host.xfer(a, 1'b1, d, q, e, ok);
      need(ok, "write");
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk = 32'hFFFFFFFF,
                         input logic experr = 1'b0);
      logic [31:0] q;
      logic e, ok;
      i_pmseq_host.xfer(a, 1'b0, 32'h00000000, q, e, ok);
      need(ok, "read");
      check_val(q & msk, exp, "read data");
      check_val(32'(e), 32'(experr), "slave error");
   endtask
   task automatic wait_sro(input logic lvl, input int b, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sro !== lvl && n < b);
      need(sro === lvl, "reset output");
   endtask
   task automatic up();
      int n;
      wait_sro(1'b1, 400, n);
      repeat (12) @(posedge pclk);
   endtask
   task automatic cycle_input();
      inpwr <= 1'b0;
      repeat (8) @(posedge pclk);
      inpwr <= 1'b1;
   endtask

   task automatic t_power_up();
      up();
      rd_chk(A_MASK, 32'h000000FF);
      rd_chk(A_PGSTAT, 32'h00000080);
      rd_chk(A_MODE, 32'h00000007, 32'h00000007);
      rd_chk(A_REGEN, 32'h00000001);
      rd_chk(8'h40, 32'h00000000, 32'hFFFFFFFF, 1'b1);
      check_val(32'(pg_en), 32'h00000001, "comparators");
      $display("test power_up done");
   endtask
   task automatic t_swrst();
      int n;
      wr(A_BUCK, 32'h2A1F0C05);
      wr(A_CTRL, 32'h00000001);
      wait_sro(1'b0, 40, n);
      wait_sro(1'b1, 200, n);
      check_val(32'(n >= RC), 32'h00000001, "reset hold");
      repeat (12) @(posedge pclk);
      rd_chk(A_CTRL, 32'h00000000, 32'h00000001);
      rd_chk(A_BUCK, 32'h2A1F0C05);
      rd_chk(A_MODE, 32'h00000007, 32'h00000007);
      $display("test swrst done");
   endtask
   task automatic t_standby();
      wr(A_CTRL, 32'h00000080);
      repeat (6) @(posedge pclk);
      check_val(32'({pfm, v2, v1}), 32'h00001A9F, "standby by register");
      wr(A_CTRL, 32'h00000000);
      repeat (6) @(posedge pclk);
      check_val(32'({pfm, v2, v1}), 32'h00000305, "normal voltages");
      stby <= 1'b1;
      repeat (8) @(posedge pclk);
      check_val(32'({pfm, v2, v1}), 32'h00001A9F, "standby by pin");
      stby <= 1'b0;
      irq <= 1'b1;
      repeat (8) @(posedge pclk);
      check_val(32'({int_oe_n, int_out}), 32'h00000000, "interrupt drive");
      irq <= 1'b0;
      $display("test standby done");
   endtask
   task automatic t_pg_sleep();
      int n;
      wr(A_REGEN, 32'h0000003F);
      wr(A_PERIPH, 32'h0000005A);
      wr(A_MASK, 32'h000000FE);
      wr(A_CTRL, 32'h00000001);
      wait_sro(1'b0, 40, n);
      supply <= 8'h81;
      irq <= 1'b1;
      wait_sro(1'b1, 200, n);
      wait_sro(1'b0, 30, n);
      repeat (3) @(posedge pclk);
      check_val(32'({int_oe_n, seq_act, regen, periph[7:0]}), 32'h00020000, "sleep outputs");
      irq <= 1'b0;
      supply <= 8'h80;
      cycle_input();
      up();
      check_val(32'(regen), 32'h00000001, "regulators after sleep");
      rd_chk(A_MASK, 32'h000000FE);
      rd_chk(A_PERIPH, 32'h00000000);
      $display("test pg_sleep done");
   endtask
   task automatic t_sleep_bit();
      int n;
      wr(A_CTRL, 32'h00000040);
      wait_sro(1'b0, 40, n);
      check_val(32'(seq_act), 32'h00000000, "sequencing in sleep");
      cycle_input();
      up();
      rd_chk(A_CTRL, 32'h00000000, 32'h00000041);
      $display("test sleep_bit done");
   endtask
   task automatic t_faults();
      int n;
      syslow <= 1'b1;
      wait_sro(1'b0, 40, n);
      syslow <= 1'b0;
      cycle_input();
      up();
      therm <= 1'b1;
      wait_sro(1'b0, 40, n);
      therm <= 1'b0;
      cycle_input();
      repeat (80) @(posedge pclk);
      check_val(32'({sro, seq_act}), 32'h00000000, "thermal sleep held");
      uvlo <= 1'b1;
      repeat (8) @(posedge pclk);
      uvlo <= 1'b0;
      up();
      rd_chk(A_MASK, 32'h000000FF);
      $display("test faults done");
   endtask
   task automatic t_pgfault();
      int n;
      wr(A_CTRL, 32'h00000002);
      rd_chk(A_CTRL, 32'h00000002, 32'h00000002);
      supply <= 8'h81;
      repeat (10) @(posedge pclk);
      check_val(32'(sro), 32'h00000001, "masked toggle");
      wr(A_MASK, 32'h0000007F);
      supply <= 8'h01;
      wait_sro(1'b0, 40, n);
      check_val(32'(seq_act), 32'h00000000, "no power");
      supply <= 8'h80;
      up();
      rd_chk(A_MASK, 32'h000000FF);
      rd_chk(A_CTRL, 32'h00000000, 32'h00000002);
      $display("test pgfault done");
   endtask
   task automatic t_hwreset();
      int n;
      hw_rst_n <= 1'b0;
      repeat (6) @(posedge pclk);
      hw_rst_n <= 1'b1;
      repeat (12) @(posedge pclk);
      check_val(32'(sro), 32'h00000001, "glitch ignored");
      wr(A_REGEN, 32'h0000003F);
      wr(A_CTRL, 32'h00000002);
      hw_rst_n <= 1'b0;
      wait_sro(1'b0, 60, n);
      check_val(32'(n > DG), 32'h00000001, "deglitch time");
      repeat (20) @(posedge pclk);
      hw_rst_n <= 1'b1;
      up();
      rd_chk(A_REGEN, 32'h00000001);
      rd_chk(A_CTRL, 32'h00000000, 32'h00000002);
      rd_chk(A_MODE, 32'h00000007, 32'h00000007);
      $display("test hwreset done");
   endtask

   initial begin
      presetn = 1'b0;
      hw_rst_n = 1'b1;
      therm = 1'b0;
      syslow = 1'b0;
      uvlo = 1'b0;
      inpwr = 1'b1;
      stby = 1'b0;
      irq = 1'b0;
      supply = 8'h80;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_power_up();
      t_swrst();
      t_standby();
      t_pg_sleep();
      t_sleep_bit();
      t_faults();
      t_pgfault();
      t_hwreset();
      test_done();
   end
endmodule
